//--- src/apbb_pkg.sv
// Shared widths, transfer carriers and state types of the APB bridge
package apbb_pkg;

    localparam int APBB_ADDR_W = 32;
    localparam int APBB_DATA_W = 32;

    localparam logic [APBB_ADDR_W-1:0] APBB_ADDR_RST = 32'h0000_0000;
    localparam logic [APBB_DATA_W-1:0] APBB_DATA_RST = 32'h0000_0000;

    // Transfer held between the two sides
    typedef struct packed {
        logic [APBB_ADDR_W-1:0] addr;
        logic write;
        logic [APBB_DATA_W-1:0] wdata;
    } apbb_cmd_t;

    // Completion returned to the upstream master
    typedef struct packed {
        logic [APBB_DATA_W-1:0] rdata;
        logic slverr;
    } apbb_rsp_t;

    localparam apbb_cmd_t APBB_CMD_RST = '{addr: APBB_ADDR_RST, write: 1'b0,
                                           wdata: APBB_DATA_RST};
    localparam apbb_rsp_t APBB_RSP_RST = '{rdata: APBB_DATA_RST, slverr: 1'b0};

    typedef enum logic [1:0] {
        APBB_S_IDLE,
        APBB_S_BUSY,
        APBB_S_RESP
    } apbb_sst_t;

    typedef enum logic [1:0] {
        APBB_M_IDLE,
        APBB_M_SETUP,
        APBB_M_ACCESS,
        APBB_M_DONE
    } apbb_mst_t;

    typedef enum logic {
        APBB_LP_RUN,
        APBB_LP_SLEEP
    } apbb_lpst_t;

endpackage

//--- src/apbb_lp_port.sv
// Low-power handshake port controller for the bridge master side
`timescale 1ns/1ns
module apbb_lp_port
    import apbb_pkg::*;
#(
    parameter bit LP_EN = 1'b1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clken_m_i,
    // Power controller side
    input wire logic lp_req_n_i,
    output logic lp_accept_n_o,
    output logic lp_active_o,
    // Bridge status
    input wire logic busy_i,
    input wire logic incoming_i,
    output logic awake_o
);

    apbb_lpst_t state_q;
    apbb_lpst_t state_d;

    wire go_sleep = LP_EN && !lp_req_n_i && !busy_i && !incoming_i;
    wire go_wake = lp_req_n_i;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            APBB_LP_RUN: begin
                if (go_sleep) begin
                    state_d = APBB_LP_SLEEP;
                end
            end
            APBB_LP_SLEEP: begin
                if (go_wake) begin
                    state_d = APBB_LP_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= APBB_LP_RUN;
        end else if (clken_m_i) begin
            state_q <= state_d;
        end
    end

    // Never sleeps and never asks for wake-up without the port
    assign awake_o = !LP_EN || (state_q == APBB_LP_RUN);
    assign lp_accept_n_o = !(LP_EN && (state_q == APBB_LP_SLEEP));
    assign lp_active_o = LP_EN && (busy_i || incoming_i);

endmodule

//--- src/apbb_bridge.sv
// APB3 to APB3 bridge and register slice with low-power handshake port
//
// Behaviour
// - Transfers cross to the master side and completions return over a req/done handshake.
// - Each side has its own clock enable and its logic advances only on enabled edges.
// - Reset is asserted asynchronously and must be released synchronously by the surroundings.
// - The bridge has one APB3 slave port and one APB3 master port with ready and error signals.
// - A power controller may request master-side low power and the bridge answers on the port.
// - Low power is accepted only when no transfer is outstanding anywhere in the bridge.
// - A new transfer while in low power raises the activity request output.
// - Once woken the bridge issues the held transfer on its master port.
// - The incoming transfer is stalled by withholding ready until the master side is awake.
// - No transfer or data is lost or duplicated by low-power entry, exit or wake-up.
// - The two sides keep all shared state in registers so either side can idle independently.
// - The bridge runs on one clock with one asynchronously asserted reset.
// - Separate master and slave clock enables qualify each side on the shared clock.
// - The transfer is registered between ports so the bridge serves as a pipeline stage.
// - The low-power port works only with LP_EN set; otherwise it never accepts low power and never raises the activity request.
`timescale 1ns/1ns
module apbb_bridge
    import apbb_pkg::*;
#(
    parameter bit LP_EN = 1'b1
) (
    // Clock, reset and side enables
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic clken_s_i,
    input wire logic clken_m_i,
    // APB slave port, from upstream master
    input wire logic s_psel_i,
    input wire logic s_penable_i,
    input wire logic s_pwrite_i,
    input wire logic [APBB_ADDR_W-1:0] s_paddr_i,
    input wire logic [APBB_DATA_W-1:0] s_pwdata_i,
    output logic s_pready_o,
    output logic [APBB_DATA_W-1:0] s_prdata_o,
    output logic s_pslverr_o,
    // APB master port, to downstream slaves
    output logic m_psel_o,
    output logic m_penable_o,
    output logic m_pwrite_o,
    output logic [APBB_ADDR_W-1:0] m_paddr_o,
    output logic [APBB_DATA_W-1:0] m_pwdata_o,
    input wire logic m_pready_i,
    input wire logic [APBB_DATA_W-1:0] m_prdata_i,
    input wire logic m_pslverr_i,
    // Low-power handshake port
    input wire logic lp_req_n_i,
    output logic lp_accept_n_o,
    output logic lp_active_o
);

    apbb_sst_t s_state_q;
    apbb_sst_t s_state_d;
    apbb_mst_t m_state_q;
    apbb_mst_t m_state_d;
    apbb_cmd_t cmd_q;
    apbb_rsp_t rsp_m_q;
    apbb_rsp_t rsp_s_q;
    logic req_q;
    logic req_d;
    logic done_q;
    logic done_d;
    logic awake;

    // State decodes shared by the take, launch and busy terms
    wire s_idle = (s_state_q == APBB_S_IDLE);
    wire m_idle = (m_state_q == APBB_M_IDLE);

    // Slave-side decode
    // Select alone suffices, so a late take still meets a held access phase
    // Waits for the last completion to retire, or a stale done ends it early
    wire s_take = clken_s_i && s_idle && s_psel_i && !done_q;
    wire s_finish = clken_s_i && (s_state_q == APBB_S_BUSY) && done_q;
    wire s_release = clken_s_i && (s_state_q == APBB_S_RESP) && s_psel_i && s_penable_i;

    // Master-side decode
    wire m_launch = clken_m_i && m_idle && req_q && !done_q && awake;
    wire m_complete = clken_m_i && (m_state_q == APBB_M_ACCESS) && m_pready_i;
    wire m_retire = clken_m_i && (m_state_q == APBB_M_DONE) && !req_q;

    // Any transfer held, in flight or awaiting return
    wire busy = req_q || done_q || !s_idle || !m_idle;

    // Slave-side state machine
    always_comb begin
        s_state_d = s_state_q;
        req_d = req_q;
        unique case (s_state_q)
            APBB_S_IDLE: begin
                if (s_take) begin
                    s_state_d = APBB_S_BUSY;
                    req_d = 1'b1;
                end
            end
            APBB_S_BUSY: begin
                if (s_finish) begin
                    s_state_d = APBB_S_RESP;
                    req_d = 1'b0;
                end
            end
            APBB_S_RESP: begin
                if (s_release) begin
                    s_state_d = APBB_S_IDLE;
                end
            end
            default: begin
                s_state_d = APBB_S_IDLE;
                req_d = 1'b0;
            end
        endcase
    end

    // Master-side state machine
    always_comb begin
        m_state_d = m_state_q;
        done_d = done_q;
        unique case (m_state_q)
            APBB_M_IDLE: begin
                if (m_launch) begin
                    m_state_d = APBB_M_SETUP;
                end
            end
            APBB_M_SETUP: begin
                if (clken_m_i) begin
                    m_state_d = APBB_M_ACCESS;
                end
            end
            APBB_M_ACCESS: begin
                if (m_complete) begin
                    m_state_d = APBB_M_DONE;
                    done_d = 1'b1;
                end
            end
            APBB_M_DONE: begin
                if (m_retire) begin
                    m_state_d = APBB_M_IDLE;
                    done_d = 1'b0;
                end
            end
        endcase
    end

    // Slave-side registers, advanced on the slave enable
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_state_q <= APBB_S_IDLE;
            req_q <= 1'b0;
        end else if (clken_s_i) begin
            s_state_q <= s_state_d;
            req_q <= req_d;
        end
    end

    // Command is captured once, on the take, in the setup or a held access phase
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_q <= APBB_CMD_RST;
        end else if (s_take) begin
            cmd_q <= '{addr: s_paddr_i, write: s_pwrite_i, wdata: s_pwdata_i};
        end
    end

    // Completion copied to the slave side once
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_s_q <= APBB_RSP_RST;
        end else if (s_finish) begin
            rsp_s_q <= rsp_m_q;
        end
    end

    // Master-side registers, advanced on the master enable
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            m_state_q <= APBB_M_IDLE;
            done_q <= 1'b0;
        end else if (clken_m_i) begin
            m_state_q <= m_state_d;
            done_q <= done_d;
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rsp_m_q <= APBB_RSP_RST;
        end else if (m_complete) begin
            rsp_m_q <= '{rdata: m_prdata_i, slverr: m_pslverr_i};
        end
    end

    // Low-power handshake
    apbb_lp_port #(
        .LP_EN(LP_EN)
    ) u_lp (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .clken_m_i(clken_m_i),
        .lp_req_n_i(lp_req_n_i),
        .lp_accept_n_o(lp_accept_n_o),
        .lp_active_o(lp_active_o),
        .busy_i(busy),
        .incoming_i(s_psel_i),
        .awake_o(awake)
    );

    // Slave port outputs; ready held low until the completion returns
    assign s_pready_o = (s_state_q == APBB_S_RESP);
    assign s_prdata_o = rsp_s_q.rdata;
    assign s_pslverr_o = rsp_s_q.slverr & s_pready_o;

    // Master port outputs from registered state and command
    assign m_psel_o = (m_state_q == APBB_M_SETUP) || (m_state_q == APBB_M_ACCESS);
    assign m_penable_o = (m_state_q == APBB_M_ACCESS);
    assign m_pwrite_o = cmd_q.write;
    assign m_paddr_o = cmd_q.addr;
    assign m_pwdata_o = cmd_q.wdata;

endmodule

//--- sim/apbb_bridge_props.sv
// Port-level checker for the APB bridge
`timescale 1ns/1ns
module apbb_bridge_props
    import apbb_pkg::*;
(
    // Clock, reset, enables and bus handshakes
    input wire logic sys_clk_i, rst_i, clken_s_i, clken_m_i, s_psel_i, s_penable_i,
    input wire logic s_pready_o, m_psel_o, m_penable_o, m_pready_i,
    // Data and low-power port
    input wire logic [APBB_DATA_W-1:0] s_prdata_o, m_pwdata_o,
    input wire logic [APBB_ADDR_W-1:0] m_paddr_o,
    input wire logic lp_req_n_i, lp_accept_n_o, lp_active_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    chk_access_order: assert property (
        m_psel_o && !m_penable_o && clken_m_i |=> m_psel_o && m_penable_o)
        else $error("access did not follow setup");
    chk_access_hold: assert property (
        m_penable_o && !(m_pready_i && clken_m_i) |=> m_penable_o && $stable(m_paddr_o)
        && $stable(m_pwdata_o))
        else $error("access phase not held");
    chk_access_end: assert property (
        m_penable_o && m_pready_i && clken_m_i |=> !m_penable_o)
        else $error("access phase did not end");
    chk_ready_hold: assert property (
        s_pready_o && !(s_psel_i && s_penable_i && clken_s_i) |=> s_pready_o
        && $stable(s_prdata_o))
        else $error("slave ready dropped early");
    chk_ready_drop: assert property (
        s_pready_o && s_psel_i && s_penable_i && clken_s_i |=> !s_pready_o)
        else $error("slave ready held too long");
    chk_sleep_quiet: assert property (
        !lp_accept_n_o |-> !m_psel_o && !s_pready_o)
        else $error("traffic while asleep");
    chk_wake_request: assert property (
        !lp_accept_n_o && s_psel_i |-> lp_active_o)
        else $error("no wake request");
    chk_entry_idle: assert property (
        $fell(lp_accept_n_o) |-> $past(!lp_active_o && !lp_req_n_i && clken_m_i))
        else $error("sleep entered while busy");
    chk_sleep_exit: assert property (
        !lp_accept_n_o && lp_req_n_i && clken_m_i |=> lp_accept_n_o)
        else $error("sleep not left");
endmodule
bind apbb_bridge apbb_bridge_props u_props (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .clken_s_i(clken_s_i),
    .clken_m_i(clken_m_i),
    .s_psel_i(s_psel_i),
    .s_penable_i(s_penable_i),
    .s_pready_o(s_pready_o),
    .m_psel_o(m_psel_o),
    .m_penable_o(m_penable_o),
    .m_pready_i(m_pready_i),
    .s_prdata_o(s_prdata_o),
    .m_pwdata_o(m_pwdata_o),
    .m_paddr_o(m_paddr_o),
    .lp_req_n_i(lp_req_n_i),
    .lp_accept_n_o(lp_accept_n_o),
    .lp_active_o(lp_active_o)
);

//--- sim/apbb_slave_model.sv
// Downstream APB slave with wait states and an error window
`timescale 1ns/1ns
module apbb_slave_model
    import apbb_pkg::*;
(
    // Clock and APB request
    input wire logic sys_clk_i, rst_i, clken_i, psel_i, penable_i, pwrite_i,
    input wire logic [APBB_ADDR_W-1:0] paddr_i,
    input wire logic [APBB_DATA_W-1:0] pwdata_i,
    input wire logic [3:0] wait_i,
    // APB response
    output logic pready_o,
    output logic [APBB_DATA_W-1:0] prdata_o,
    output logic pslverr_o
);
    logic [APBB_DATA_W-1:0] mem_q [16];
    logic [APBB_DATA_W-1:0] last_q;
    logic [3:0] cnt_q;
    wire logic err = paddr_i[12];
    assign pready_o = psel_i && penable_i && cnt_q == wait_i;
    // Released bus shows the inverse of the last value
    assign prdata_o = pready_o ? mem_q[paddr_i[5:2]] : ~last_q;
    assign pslverr_o = pready_o ? err : ~last_q[0];
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 4'h0;
            last_q <= '0;
        end else if (clken_i) begin
            cnt_q <= (psel_i && penable_i && !pready_o) ? cnt_q + 4'h1 : 4'h0;
            if (pready_o) begin
                last_q <= prdata_o;
                if (pwrite_i && !err) mem_q[paddr_i[5:2]] <= pwdata_i;
            end
        end
    end
endmodule

//--- sim/apbb_bridge_test.sv
// Self-checking bench for the APB bridge
`timescale 1ns/1ns
module apbb_bridge_test;
    import apbb_pkg::*;
    logic sys_clk_i = 0, rst_i = 1, clken_s_i = 1, clken_m_i = 1, gate = 0;
    logic s_psel_i = 0, s_penable_i = 0, s_pwrite_i = 0, lp_req_n_i = 1, er;
    logic [31:0] s_paddr_i = '0, s_pwdata_i = '0, s_prdata_o, m_paddr_o, m_pwdata_o;
    logic [31:0] m_prdata_i, rd;
    logic s_pready_o, s_pslverr_o, m_psel_o, m_penable_o, m_pwrite_o, m_pready_i, m_pslverr_i;
    logic lp_accept_n_o, lp_active_o;
    logic [3:0] wait_i = 4'h3;
    int err_count = 0, compares = 0, cyc = 0;
    apbb_bridge u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clken_s_i(clken_s_i),
        .clken_m_i(clken_m_i), .s_psel_i(s_psel_i), .s_penable_i(s_penable_i),
        .s_pwrite_i(s_pwrite_i), .s_paddr_i(s_paddr_i), .s_pwdata_i(s_pwdata_i),
        .s_pready_o(s_pready_o), .s_prdata_o(s_prdata_o), .s_pslverr_o(s_pslverr_o),
        .m_psel_o(m_psel_o), .m_penable_o(m_penable_o), .m_pwrite_o(m_pwrite_o),
        .m_paddr_o(m_paddr_o), .m_pwdata_o(m_pwdata_o), .m_pready_i(m_pready_i),
        .m_prdata_i(m_prdata_i), .m_pslverr_i(m_pslverr_i), .lp_req_n_i(lp_req_n_i),
        .lp_accept_n_o(lp_accept_n_o), .lp_active_o(lp_active_o));
    apbb_slave_model u_slave (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .clken_i(clken_m_i),
        .psel_i(m_psel_o), .penable_i(m_penable_o), .pwrite_i(m_pwrite_o), .paddr_i(m_paddr_o),
        .pwdata_i(m_pwdata_o), .wait_i(wait_i), .pready_o(m_pready_i), .prdata_o(m_prdata_i),
        .pslverr_o(m_pslverr_i));
    always #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        #1;
        cyc++;
        if (gate) begin
            clken_m_i = ~clken_m_i;
            clken_s_i = (cyc % 3) != 0;
        end
        if (cyc == 4000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        if (err_count == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, d);
        @(posedge sys_clk_i) #1;
        {s_psel_i, s_penable_i, s_pwrite_i, s_paddr_i, s_pwdata_i} = {2'b10, wr, a, d};
        do @(posedge sys_clk_i); while (clken_s_i !== 1'b1);
        #1 s_penable_i = 1'b1;
        do @(negedge sys_clk_i); while (!(s_pready_o === 1'b1 && clken_s_i));
        rd = s_prdata_o;
        er = s_pslverr_o;
        @(posedge sys_clk_i) #1;
        {s_psel_i, s_penable_i} = 2'b00;
    endtask
    task automatic xchk(input logic wr, input logic [31:0] a, d, input logic e);
        xfer(wr, a, d);
        if (!wr) chk("read data", d, rd);
        chk("error response", {31'h0, e}, {31'h0, er});
    endtask
    task automatic wait_lp(input logic v);
        for (int n = 0; lp_accept_n_o !== v && n < 50; n++) @(negedge sys_clk_i);
        chk("lp accept", {31'h0, v}, {31'h0, lp_accept_n_o});
    endtask
    task automatic t_basic();
        xchk(1'b1, 32'h10, 32'ha5a5_0001, 1'b0);
        wait_i = 4'h0;
        xchk(1'b1, 32'h1014, 32'hffff_ffff, 1'b1);
        gate = 1'b1;
        xchk(1'b1, 32'h14, 32'h5a5a_0002, 1'b0);
        xchk(1'b0, 32'h10, 32'ha5a5_0001, 1'b0);
        xchk(1'b0, 32'h14, 32'h5a5a_0002, 1'b0);
    endtask
    task automatic t_lowpower();
        @(posedge sys_clk_i) #1 lp_req_n_i = 1'b0;
        wait_lp(1'b0);
        fork
            xfer(1'b0, 32'h10, 32'h0);
            begin
                repeat (6) @(negedge sys_clk_i);
                chk("wake request", 32'h1, {31'h0, lp_active_o});
                chk("stalled ready", 32'h0, {31'h0, s_pready_o});
                chk("held select", 32'h0, {31'h0, m_psel_o});
                #6 lp_req_n_i = 1'b1;
            end
        join
        chk("read after wake", 32'ha5a5_0001, rd);
    endtask
    task automatic t_lp_busy();
        wait_i = 4'h8;
        fork
            xchk(1'b1, 32'h1c, 32'h0bad_cafe, 1'b0);
            begin
                repeat (4) @(negedge sys_clk_i);
                #6 lp_req_n_i = 1'b0;
                repeat (5) @(negedge sys_clk_i);
                chk("accept while busy", 32'h1, {31'h0, lp_accept_n_o});
            end
        join
        wait_lp(1'b0);
        @(posedge sys_clk_i) #1 lp_req_n_i = 1'b1;
        wait_lp(1'b1);
        xchk(1'b0, 32'h1c, 32'h0bad_cafe, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge sys_clk_i);
        #1 rst_i = 1'b0;
        t_basic();
        t_lowpower();
        t_lp_busy();
        complete_run();
    end
endmodule
